//--- bench/nfc_card_model.sv
// card model: one page of cells, read pointer, status and id modes
// assumes host strobes; tb_top resolves dq and drv onto the shared bus
`timescale 1ns/1ps
`default_nettype none
module nfc_card_model #(
	parameter logic [7:0] MAKER = 8'h5a,
	parameter logic [7:0] DEVID = 8'h3c,
	parameter realtime T_ERASE = 3000
) (
	input wire logic cmd_latch, addr_latch, wr_strobe_n, out_strobe_n, chip_sel_n, protect_n,
	input wire logic [7:0] io_out,
	output logic [7:0] dq,
	output logic drv,
	output logic ready_busy_n
);
	// identity codes are arbitrary; the page address is ignored, one page serves all
	logic [7:0] mem [528];
	logic [9:0] col, base;
	logic [7:0] cmd;
	logic [1:0] na, mode;
	logic loaded, idn;
	realtime busy_end;
	task automatic busy(input realtime t);
		busy_end = $realtime + t;
		ready_busy_n = 1'b0;
	endtask
	initial begin
		foreach (mem[i]) mem[i] = 8'hff;
		{base, col, cmd, na, mode, loaded, idn, dq} = '0;
		busy_end = 0;
		ready_busy_n = 1'b1;
	end
	always #1 if ($realtime >= busy_end) ready_busy_n = 1'b1;
	assign drv = !out_strobe_n && !chip_sel_n;
	always @(posedge wr_strobe_n) if (!chip_sel_n) begin
		if (cmd_latch && (ready_busy_n || io_out == 8'h70 || io_out == 8'hff)) begin
			case (io_out)
			8'h00, 8'h01, 8'h50: begin
				{cmd, mode, na} = {io_out, 4'h0};
				base = (io_out == 8'h50) ? 10'h200 : {io_out[1:0], 8'h00};
			end
			8'h80, 8'h60: {cmd, mode, na, loaded} = {io_out, 5'h0};
			8'h10: if (cmd == 8'h80 && loaded) begin
				{mode, cmd} = {2'h1, 8'h00};
				busy(200);
				if (base == 10'h100) base = 0;
			end
			8'hd0: if (cmd == 8'h60 && na == 2) begin
				foreach (mem[i]) mem[i] = 8'hff;
				{mode, cmd} = {2'h1, 8'h00};
				busy(T_ERASE);
			end
			8'h70: mode = 1;
			8'h90: {cmd, mode, na, idn} = {io_out, 2'h2, 3'h0};
			8'hff: if (mode != 3) begin
				{mode, cmd, base} = {2'h3, 18'h0};
				busy(100);
			end
			default: ;
			endcase
		end else if (addr_latch) begin
			if (na == 0 && cmd != 8'h60)
				col = base | (base[9] ? {6'h00, io_out[3:0]} : {2'b00, io_out});
			na = na + 1;
			if (na == 3 && cmd != 8'h80) busy(100);
		end else if (cmd == 8'h80) begin
			mem[col] = mem[col] & io_out;
			col = col + 1;
			loaded = 1;
		end
	end
	always @(negedge out_strobe_n) if (!chip_sel_n) begin
		if (mode == 1) dq = {protect_n, ready_busy_n, 6'h00};
		else if (mode == 2) begin
			dq = idn ? DEVID : MAKER;
			idn = 1;
		end else begin
			dq = mem[col];
			col = col + 1;
			if (base == 10'h100) base = 0;
			if (col == 10'd528 || (base[9] && col[3:0] == 4'h0)) begin
				col = base;
				busy(100);
			end
		end
	end
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// self-checking bench: apb master, card model, queue of expected reads
// assumes nfc_host answers apb at once; each poll gives up after 2000 status reads
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct {string n; logic [31:0] m; logic [31:0] v;} nfc_exp_t;
	logic mclk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, chk = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, rd, prdata;
	logic pready, pslverr, cmd_latch, addr_latch, wr_strobe_n, out_strobe_n;
	logic chip_sel_n, protect_n, io_oe, drv, ready_busy_n, se;
	logic [7:0] io_out, dq, io_in, ex [8], b [4];
	nfc_exp_t expq [$];
	nfc_exp_t e;
	realtime t;
	int errors = 0, comparisons = 0;
	localparam logic [7:0] MK = 8'h5a; // arbitrary
	localparam logic [7:0] DV = 8'h3c; // arbitrary
	// a released bus shows the inverse of the last byte, never a held value
	assign io_in = io_oe ? io_out : drv ? dq : ~dq;
	initial forever #2.5 mclk = ~mclk;
	nfc_host u_dut (.mclk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .cmd_latch, .addr_latch, .wr_strobe_n, .out_strobe_n,
		.chip_sel_n, .protect_n, .io_out, .io_oe, .io_in, .ready_busy_n);
	nfc_card_model #(.MAKER(MK), .DEVID(DV)) u_card (.cmd_latch, .addr_latch, .wr_strobe_n,
		.out_strobe_n, .chip_sel_n, .protect_n, .io_out, .dq, .drv, .ready_busy_n);
	task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
		comparisons++;
		if (s !== x) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic final_report();
		$display("summary: %0d comparisons, %0d errors", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
		@(posedge mclk);
		{psel, pwrite, paddr, pwdata, chk} <= {1'b1, w, a, d, c};
		@(posedge mclk);
		penable <= 1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		{psel, penable, chk} <= 3'b000;
	endtask
	always @(posedge mclk) if (psel && penable && pready === 1'b1 && chk) begin
		e = expq.pop_front();
		check(e.n, prdata & e.m, e.v);
	end
	task automatic rdx(input logic [7:0] a, input logic [31:0] m, v, input string n);
		expq.push_back('{n, m, v});
		apb(0, a, 0, 1);
	endtask
	task automatic poll(input int bt, input logic val);
		for (int i = 0; i < 2000; i++) begin
			apb(0, nfc_pkg::REG_STATUS, 0, 0);
			if (rd[bt] === val) break;
		end
	endtask
	task automatic go(input logic [2:0] op, input logic [23:0] a, input logic [15:0] n);
		apb(1, nfc_pkg::REG_ADDR, 32'(a), 0);
		apb(1, nfc_pkg::REG_COUNT, 32'(n), 0);
		apb(1, nfc_pkg::REG_CMD, 32'(op), 0);
	endtask
	task automatic fin();
		poll(nfc_pkg::ST_DONE_BIT, 1);
		apb(1, nfc_pkg::REG_STATUS, 32'h6, 0);
	endtask
	task automatic rd_bytes(input logic [2:0] op, input logic [23:0] a, input int n);
		go(op, a, 16'(n));
		for (int i = 0; i < n; i++) begin
			poll(3, 1);
			rdx(nfc_pkg::REG_RDATA, 32'hff, 32'(ex[i]), "card byte");
		end
		fin();
	endtask
	task automatic prog(input logic [23:0] a, input int n);
		apb(1, nfc_pkg::REG_WDATA, 32'(b[0]), 0);
		go(nfc_pkg::OP_PROG, a, 16'(n));
		for (int i = 1; i < n; i++) begin
			poll(4, 0);
			apb(1, nfc_pkg::REG_WDATA, 32'(b[i]), 0);
		end
		fin();
	endtask
	initial begin
		void'($urandom(91));
		foreach (b[i]) b[i] = 8'($urandom);
		repeat (16) @(posedge mclk);
		arst_n <= 1;
		repeat (3) @(posedge mclk);
		rdx(nfc_pkg::REG_STATUS, 32'hff00, 32'hc000, "reset flags");
		rdx(8'h1c, 32'hffffffff, 32'h0, "unmapped read");
		check("unmapped error", 32'(se), 32'h1);
		apb(1, nfc_pkg::REG_CTRL, 32'h1, 0);
		prog(24'h000005, 4);
		rdx(nfc_pkg::REG_STATUS, 32'hff00, 32'hc000, "prog flags");
		foreach (b[i]) ex[i] = b[i];
		rd_bytes(nfc_pkg::OP_READ_MAIN, 24'h000005, 4);
		$display("test program and main read done");
		apb(1, nfc_pkg::REG_CTRL, 32'h3, 0);
		prog(24'h000003, 1);
		foreach (ex[i]) ex[i] = 8'hff;
		ex[0] = b[0];
		rd_bytes(nfc_pkg::OP_READ_SPARE, 24'h000013, 2);
		// spare read across the page end wraps to the start of the same spare field
		ex[0] = 8'hff;
		ex[7] = b[0];
		rd_bytes(nfc_pkg::OP_READ_SPARE, 24'h00000c, 8);
		rd_bytes(nfc_pkg::OP_READ_HALF2, 24'h0000fc, 8);
		apb(1, nfc_pkg::REG_CTRL, 32'h1, 0);
		prog(24'h000009, 1);
		go(nfc_pkg::OP_PROG, 24'h000009, 1);
		rdx(nfc_pkg::REG_STATUS, 32'h4, 32'h4, "third program refused");
		apb(1, nfc_pkg::REG_STATUS, 32'h4, 0);
		go(nfc_pkg::OP_PROG, 24'h000009, 0);
		rdx(nfc_pkg::REG_STATUS, 32'h4, 32'h4, "empty program refused");
		apb(1, nfc_pkg::REG_STATUS, 32'h4, 0);
		$display("test spare and refusals done");
		apb(1, nfc_pkg::REG_CTRL, 32'h0, 0);
		ex[0] = 8'h40;
		rd_bytes(nfc_pkg::OP_STATUS, 0, 1);
		ex[0] = MK;
		ex[1] = DV;
		rd_bytes(nfc_pkg::OP_ID, 0, 2);
		apb(1, nfc_pkg::REG_CTRL, 32'h1, 0);
		go(nfc_pkg::OP_ERASE, 24'h004000, 0);
		fin();
		rdx(nfc_pkg::REG_STATUS, 32'hff00, 32'hc000, "erase flags");
		ex[0] = 8'hff;
		rd_bytes(nfc_pkg::OP_READ_MAIN, 24'h000005, 1);
		$display("test status id erase done");
		go(nfc_pkg::OP_ERASE, 24'h004000, 0);
		t = $realtime;
		repeat (100) @(posedge mclk);
		apb(1, nfc_pkg::REG_CMD, 32'(nfc_pkg::OP_RESET), 0);
		fin();
		check("abort early", 32'($realtime - t < 2500), 32'h1);
		rdx(nfc_pkg::REG_STATUS, 32'hff00, 32'hc000, "abort flags");
		$display("test reset abort done");
		final_report();
	end
	// whole run is a few thousand cycles; this allows about thirty times that
	initial begin
		#400000;
		errors++;
		final_report();
	end
endmodule
`default_nettype wire

//--- core/nfc_host.sv
// host controller that drives a nand flash card over its strobe pins
// assumes an apb master on mclk, and the tri-state bus resolved outside
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - main read sends 00H then three address bytes
// - after last column the host waits for reload; ends reading with chip_sel_n high
// - main reads always reissue 00H or 01H to leave the spare pointer
// - host refuses a third main or fourth spare program of one page
// - program sends 00H or 50H, 80H, three address bytes, data bytes, then 10H
// - erase sends 60H, two row address bytes, then D0H
// - reads after a status read start again with a read command
// - id read sends 90H, address 00H, then takes two bytes
module nfc_host #(
	parameter int CNT_W = 16
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic cmd_latch,
	output logic addr_latch,
	output logic wr_strobe_n,
	output logic out_strobe_n,
	output logic chip_sel_n,
	output logic protect_n,
	output logic [7:0] io_out,
	output logic io_oe,
	input wire logic [7:0] io_in,
	input wire logic ready_busy_n
);
	typedef enum logic [3:0] {S_IDLE, S_CMD, S_ADDR, S_DWAIT, S_DIN, S_WAIT, S_RDY, S_WHR,
		S_RWAIT, S_RD, S_CEH} nfc_state_t;

	logic rst_m_q, rst_n_q;
	logic [8:0] sync_q;
	logic rb_s;
	logic [7:0] io_s;
	nfc_state_t state_q;
	logic ph_q;
	logic [nfc_pkg::TMR_W-1:0] tmr_q;
	logic [7:0] cmd_q, dout_q, wdata_q, rdata_q, result_q;
	logic [1:0] aidx_q, ctrl_q, main_cnt_q, spare_cnt_q;
	logic [CNT_W-1:0] left_q, cnt_q;
	logic [9:0] col_q;
	logic [2:0] op_q;
	logic [23:0] addr_q;
	logic [14:0] last_page_q;
	logic wfull_q, rfull_q, done_q, refused_q;
	logic acc, wr_en, rd_en, cmd_wr, same_page, limit_hit, start, abort, refuse;
	logic tick, wcyc_end, capture, to_sw, is_read;
	logic [2:0] new_op;

	function automatic logic mapped(input logic [7:0] a);
		case (a)
			nfc_pkg::REG_CMD, nfc_pkg::REG_ADDR, nfc_pkg::REG_COUNT, nfc_pkg::REG_CTRL,
			nfc_pkg::REG_STATUS, nfc_pkg::REG_WDATA, nfc_pkg::REG_RDATA: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction

	function automatic logic [7:0] first_cmd(input logic [2:0] op, input logic spare);
		case (op)
			nfc_pkg::OP_READ_MAIN: first_cmd = nfc_pkg::CMD_READ_MAIN;
			nfc_pkg::OP_READ_HALF2: first_cmd = nfc_pkg::CMD_READ_HALF2;
			nfc_pkg::OP_READ_SPARE: first_cmd = nfc_pkg::CMD_READ_SPARE;
			nfc_pkg::OP_PROG: first_cmd = spare ? nfc_pkg::CMD_READ_SPARE : nfc_pkg::CMD_READ_MAIN;
			nfc_pkg::OP_ERASE: first_cmd = nfc_pkg::CMD_ERASE_SETUP;
			nfc_pkg::OP_STATUS: first_cmd = nfc_pkg::CMD_STATUS;
			nfc_pkg::OP_ID: first_cmd = nfc_pkg::CMD_ID;
			default: first_cmd = nfc_pkg::CMD_RESET;
		endcase
	endfunction

	function automatic logic [7:0] addr_byte(input logic [2:0] op, input logic [1:0] idx,
		input logic [23:0] a, input logic spare);
		if (op == nfc_pkg::OP_ID) begin
			addr_byte = nfc_pkg::ID_ADDR;
		end else begin
			case (idx)
				2'h0: addr_byte = spare ? {4'h0, a[3:0]} : a[7:0];
				2'h1: addr_byte = a[16:9];
				default: addr_byte = {1'b0, a[23:17]};
			endcase
		end
	endfunction

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rst_m_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_n_q <= rst_m_q;
		end
	end

	nfc_sync #(.W(9)) u_sync (
		.clk(mclk),
		.rst_n(rst_n_q),
		.d({ready_busy_n, io_in}),
		.q(sync_q)
	);
	assign rb_s = sync_q[8];
	assign io_s = sync_q[7:0];

	// apb slave: no wait states, read data latched in the setup cycle
	assign acc = psel && penable;
	assign wr_en = acc && pwrite;
	assign rd_en = acc && !pwrite;
	assign pready = 1'b1;
	assign pslverr = acc && !mapped(paddr);
	assign cmd_wr = wr_en && (paddr == nfc_pkg::REG_CMD);
	assign new_op = pwdata[2:0];
	assign same_page = (addr_q[23:9] == last_page_q);
	assign limit_hit = (new_op == nfc_pkg::OP_PROG) && same_page && (ctrl_q[nfc_pkg::CTRL_SPARE_BIT] ?
		(spare_cnt_q >= nfc_pkg::PROG_SPARE_MAX) : (main_cnt_q >= nfc_pkg::PROG_MAIN_MAX));
	// a program with no data would leave 10H unanswered by the card
	assign start = cmd_wr && (state_q == S_IDLE) && !limit_hit &&
		!((new_op == nfc_pkg::OP_PROG) && (cnt_q == '0));
	assign abort = cmd_wr && (new_op == nfc_pkg::OP_RESET) &&
		((state_q == S_RDY) || (state_q == S_WAIT));
	assign refuse = cmd_wr && !start && !abort;

	assign tick = (tmr_q == '0);
	assign wcyc_end = ph_q && tick;
	assign capture = (state_q == S_RD) && !ph_q && tick;
	assign is_read = (op_q == nfc_pkg::OP_READ_MAIN) || (op_q == nfc_pkg::OP_READ_HALF2) ||
		(op_q == nfc_pkg::OP_READ_SPARE);
	assign to_sw = is_read || (op_q == nfc_pkg::OP_STATUS) || (op_q == nfc_pkg::OP_ID);

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			prdata <= 32'h0;
		end else if (psel && !penable) begin
			case (paddr)
				nfc_pkg::REG_CMD: prdata <= {29'h0, op_q};
				nfc_pkg::REG_ADDR: prdata <= {8'h00, addr_q};
				nfc_pkg::REG_COUNT: prdata <= 32'(cnt_q);
				nfc_pkg::REG_CTRL: prdata <= {30'h0, ctrl_q};
				nfc_pkg::REG_STATUS: prdata <= {16'h0, result_q, 2'h0, rb_s, wfull_q, rfull_q,
					refused_q, done_q, state_q != S_IDLE};
				nfc_pkg::REG_RDATA: prdata <= {24'h0, rdata_q};
				default: prdata <= 32'h0;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			addr_q <= 24'h0;
			cnt_q <= '0;
			ctrl_q <= nfc_pkg::CTRL_RESET;
			op_q <= nfc_pkg::OP_READ_MAIN;
		end else begin
			if (wr_en && paddr == nfc_pkg::REG_ADDR) addr_q <= pwdata[23:0];
			if (wr_en && paddr == nfc_pkg::REG_COUNT) cnt_q <= pwdata[CNT_W-1:0];
			if (wr_en && paddr == nfc_pkg::REG_CTRL) ctrl_q <= pwdata[1:0];
			if (start || abort) op_q <= new_op;
		end
	end

	// sticky flags: clear first so a same-cycle event still wins
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			done_q <= 1'b0;
			refused_q <= 1'b0;
			wfull_q <= 1'b0;
			wdata_q <= 8'h00;
		end else begin
			if (wr_en && paddr == nfc_pkg::REG_STATUS) begin
				if (pwdata[nfc_pkg::ST_DONE_BIT]) done_q <= 1'b0;
				if (pwdata[nfc_pkg::ST_REFUSED_BIT]) refused_q <= 1'b0;
			end
			if (state_q == S_CEH && tick) done_q <= 1'b1;
			if (refuse) refused_q <= 1'b1;
			if (state_q == S_DWAIT) wfull_q <= 1'b0;
			if (wr_en && paddr == nfc_pkg::REG_WDATA) begin
				wfull_q <= 1'b1;
				wdata_q <= pwdata[7:0];
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rfull_q <= 1'b0;
			rdata_q <= 8'h00;
			result_q <= nfc_pkg::RESULT_RESET;
		end else begin
			if (rd_en && paddr == nfc_pkg::REG_RDATA) rfull_q <= 1'b0;
			if (capture && to_sw) begin
				rfull_q <= 1'b1;
				rdata_q <= io_s;
			end
			if (capture && !is_read && op_q != nfc_pkg::OP_ID) result_q <= io_s;
		end
	end

	// one page remembered; counts programs since its last erase
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			last_page_q <= '1;
			main_cnt_q <= 2'h0;
			spare_cnt_q <= 2'h0;
		end else if (start && new_op == nfc_pkg::OP_PROG) begin
			if (!same_page) begin
				last_page_q <= addr_q[23:9];
				main_cnt_q <= 2'h0;
				spare_cnt_q <= 2'h0;
			end
			if (ctrl_q[nfc_pkg::CTRL_SPARE_BIT]) begin
				spare_cnt_q <= (same_page ? spare_cnt_q : 2'h0) + 2'h1;
			end else begin
				main_cnt_q <= (same_page ? main_cnt_q : 2'h0) + 2'h1;
			end
		end else if (start && new_op == nfc_pkg::OP_ERASE && addr_q[23:14] == last_page_q[14:5]) begin
			main_cnt_q <= 2'h0;
			spare_cnt_q <= 2'h0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= S_IDLE;
			ph_q <= 1'b0;
			tmr_q <= '0;
			cmd_q <= nfc_pkg::CMD_READ_MAIN;
			aidx_q <= 2'h0;
			left_q <= '0;
			col_q <= 10'h0;
			dout_q <= 8'h00;
		end else if (abort) begin
			state_q <= S_CMD;
			cmd_q <= nfc_pkg::CMD_RESET;
			ph_q <= 1'b0;
			tmr_q <= nfc_pkg::WE_LO_T;
		end else begin
			if (!tick) tmr_q <= tmr_q - 1'b1;
			case (state_q)
				S_IDLE: begin
					if (start) begin
						state_q <= S_CMD;
						ph_q <= 1'b0;
						tmr_q <= nfc_pkg::WE_LO_T;
						cmd_q <= first_cmd(new_op, ctrl_q[nfc_pkg::CTRL_SPARE_BIT]);
						aidx_q <= (new_op == nfc_pkg::OP_ERASE) ? nfc_pkg::ERASE_FIRST : 2'h0;
						if (new_op == nfc_pkg::OP_ID) left_q <= CNT_W'(nfc_pkg::ID_READS);
						else if (new_op == nfc_pkg::OP_STATUS) left_q <= CNT_W'(1);
						else left_q <= cnt_q;
						case (new_op)
							nfc_pkg::OP_READ_HALF2: col_q <= nfc_pkg::COL_HALF2 + {2'h0, addr_q[7:0]};
							nfc_pkg::OP_READ_SPARE: col_q <= nfc_pkg::COL_SPARE + {6'h0, addr_q[3:0]};
							default: col_q <= {2'h0, addr_q[7:0]};
						endcase
					end
				end
				S_CMD, S_ADDR, S_DIN: begin
					if (!ph_q && tick) begin
						ph_q <= 1'b1;
						tmr_q <= nfc_pkg::WE_HI_T;
					end else if (wcyc_end) begin
						ph_q <= 1'b0;
						tmr_q <= nfc_pkg::WE_LO_T;
						if (state_q == S_CMD) begin
							case (cmd_q)
								nfc_pkg::CMD_READ_MAIN, nfc_pkg::CMD_READ_HALF2, nfc_pkg::CMD_READ_SPARE: begin
									if (op_q == nfc_pkg::OP_PROG) cmd_q <= nfc_pkg::CMD_DATA_IN;
									else state_q <= S_ADDR;
								end
								nfc_pkg::CMD_DATA_IN, nfc_pkg::CMD_ERASE_SETUP, nfc_pkg::CMD_ID: state_q <= S_ADDR;
								nfc_pkg::CMD_STATUS: begin
									state_q <= S_WHR;
									tmr_q <= nfc_pkg::WHR_T;
								end
								default: begin
									state_q <= S_WAIT;
									tmr_q <= nfc_pkg::TRB_T;
								end
							endcase
						end else if (state_q == S_DIN) begin
							left_q <= left_q - 1'b1;
							if (left_q == CNT_W'(1)) begin
								state_q <= S_CMD;
								cmd_q <= nfc_pkg::CMD_PROG_GO;
							end else begin
								state_q <= S_DWAIT;
							end
						end else if (op_q == nfc_pkg::OP_ID || aidx_q == nfc_pkg::ADDR_LAST) begin
							case (op_q)
								nfc_pkg::OP_PROG: state_q <= S_DWAIT;
								nfc_pkg::OP_ERASE: begin
									state_q <= S_CMD;
									cmd_q <= nfc_pkg::CMD_ERASE_GO;
								end
								nfc_pkg::OP_ID: begin
									state_q <= S_WHR;
									tmr_q <= nfc_pkg::WHR_T;
								end
								default: begin
									state_q <= S_WAIT;
									tmr_q <= nfc_pkg::TRB_T;
								end
							endcase
						end else begin
							aidx_q <= aidx_q + 2'h1;
						end
					end
				end
				S_DWAIT: begin
					if (wfull_q) begin
						state_q <= S_DIN;
						dout_q <= wdata_q;
						tmr_q <= nfc_pkg::WE_LO_T;
					end
				end
				S_WAIT: if (tick) state_q <= S_RDY;
				S_RDY: begin
					// busy window: only status or reset may reach the card
					if (rb_s) begin
						ph_q <= 1'b0;
						if (is_read) begin
							state_q <= S_RWAIT;
						end else if (op_q == nfc_pkg::OP_RESET) begin
							state_q <= S_CEH;
							tmr_q <= nfc_pkg::CEH_T;
						end else begin
							state_q <= S_CMD;
							cmd_q <= nfc_pkg::CMD_STATUS;
							tmr_q <= nfc_pkg::WE_LO_T;
							// program data loop left the count at zero, erase left the COUNT value; the status read is one byte
							left_q <= CNT_W'(1);
						end
					end
				end
				S_WHR: if (tick) state_q <= S_RWAIT;
				S_RWAIT: begin
					// software backpressure: no strobe until the last byte was taken
					if (!rfull_q || !to_sw) begin
						state_q <= S_RD;
						ph_q <= 1'b0;
						tmr_q <= nfc_pkg::RD_LO_T;
					end
				end
				S_RD: begin
					if (!ph_q && tick) begin
						ph_q <= 1'b1;
						tmr_q <= nfc_pkg::RD_HI_T;
					end else if (wcyc_end) begin
						ph_q <= 1'b0;
						left_q <= left_q - 1'b1;
						if (left_q == CNT_W'(1)) begin
							state_q <= S_CEH;
							tmr_q <= nfc_pkg::CEH_T;
						end else if (is_read && col_q == nfc_pkg::COL_LAST) begin
							col_q <= (op_q == nfc_pkg::OP_READ_SPARE) ? nfc_pkg::COL_SPARE : 10'h0;
							state_q <= S_WAIT;
							tmr_q <= nfc_pkg::TRB_T;
						end else begin
							col_q <= col_q + 10'h1;
							state_q <= S_RWAIT;
						end
					end
				end
				S_CEH: if (tick) state_q <= S_IDLE;
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// pins from flops; one cycle behind the sequencer state
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cmd_latch <= 1'b0;
			addr_latch <= 1'b0;
			wr_strobe_n <= 1'b1;
			out_strobe_n <= 1'b1;
			chip_sel_n <= 1'b1;
			protect_n <= 1'b0;
			io_out <= 8'h00;
			io_oe <= 1'b0;
		end else begin
			cmd_latch <= (state_q == S_CMD);
			addr_latch <= (state_q == S_ADDR);
			wr_strobe_n <= !(((state_q == S_CMD) || (state_q == S_ADDR) || (state_q == S_DIN)) && !ph_q);
			out_strobe_n <= !((state_q == S_RD) && !ph_q);
			chip_sel_n <= (state_q == S_IDLE) || (state_q == S_CEH);
			protect_n <= ctrl_q[nfc_pkg::CTRL_PROT_BIT];
			io_oe <= (state_q == S_CMD) || (state_q == S_ADDR) || (state_q == S_DIN);
			case (state_q)
				S_CMD: io_out <= cmd_q;
				S_ADDR: io_out <= addr_byte(op_q, aidx_q, addr_q, op_q == nfc_pkg::OP_READ_SPARE ||
					(op_q == nfc_pkg::OP_PROG && ctrl_q[nfc_pkg::CTRL_SPARE_BIT]));
				S_DIN: io_out <= dout_q;
				default: io_out <= 8'h00;
			endcase
		end
	end

	logic [nfc_pkg::TMR_W-1:0] re_lo_q;

	// counts read strobe low cycles; a long repetition would be too slow to check
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			re_lo_q <= '0;
		end else begin
			re_lo_q <= out_strobe_n ? '0 : re_lo_q + 1'b1;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n_q);

	sequence seq_reset_on_pins;
		cmd_latch && io_oe && (io_out == nfc_pkg::CMD_RESET);
	endsequence

	AST_RE_LOW: assert property ($rose(out_strobe_n) |-> re_lo_q == nfc_pkg::RD_LO_T + 1'b1)
		else $error("read strobe low time wrong");
	AST_RE_HIGH: assert property ($rose(out_strobe_n) |-> out_strobe_n [*5])
		else $error("read strobe high time too short");
	AST_WE_LOW: assert property ($fell(wr_strobe_n) |-> !wr_strobe_n [*5] ##1 wr_strobe_n)
		else $error("write strobe low time wrong");
	AST_LATCH_EXCL: assert property (!(cmd_latch && addr_latch))
		else $error("command and address latch both high");
	AST_OE_ON_WRITE: assert property (!wr_strobe_n |-> io_oe && !out_strobe_n == 1'b0)
		else $error("write strobe without bus drive");
	AST_CE_END: assert property ((state_q == S_CEH && $past(state_q) != S_CEH) |=> chip_sel_n [*3])
		else $error("chip select not raised at end");
	AST_BUSY_HOLD: assert property ((state_q == S_RDY && !rb_s && !abort) |=> state_q == S_RDY)
		else $error("left busy wait while card busy");
	AST_CONFIRM_AFTER_DATA: assert property ((state_q == S_CMD && cmd_q == nfc_pkg::CMD_PROG_GO &&
		$past(state_q) != S_CMD) |-> $past(state_q) == S_DIN)
		else $error("program confirm without data");
	AST_PROG_LIMIT: assert property ((start && new_op == nfc_pkg::OP_PROG) |=>
		main_cnt_q <= nfc_pkg::PROG_MAIN_MAX && spare_cnt_q <= nfc_pkg::PROG_SPARE_MAX)
		else $error("partial program count exceeded");
	AST_ABORT_RESET: assert property (abort |-> ##2 seq_reset_on_pins)
		else $error("abort did not send reset");
	AST_PAGE_WRAP: assert property ((wcyc_end && state_q == S_RD && left_q != CNT_W'(1) && is_read &&
		col_q == nfc_pkg::COL_LAST) |=> state_q == S_WAIT && (col_q == nfc_pkg::COL_SPARE ||
		col_q == 10'h0))
		else $error("no reload wait at page end");
endmodule
`default_nettype wire

//--- core/nfc_pkg.sv
// constants for the host-side nand flash command sequencer
// assumes a 200 MHz mclk; every time figure below is turned into cycles here
package nfc_pkg;
	localparam int CLK_NS = 5;

	// strobe and wait times in ns, then timer loads: whole cycles rounded up, less one
	localparam int WE_LO_NS = 25;
	localparam int WE_HI_NS = 25;
	localparam int RD_LO_NS = 55;
	localparam int RD_HI_NS = 25;
	localparam int TRB_NS = 100;
	localparam int WHR_NS = 60;
	localparam int CEH_NS = 100;
	localparam int TMR_W = 8;
	localparam logic [TMR_W-1:0] WE_LO_T = TMR_W'((WE_LO_NS + CLK_NS - 1) / CLK_NS - 1);
	localparam logic [TMR_W-1:0] WE_HI_T = TMR_W'((WE_HI_NS + CLK_NS - 1) / CLK_NS - 1);
	localparam logic [TMR_W-1:0] RD_LO_T = TMR_W'((RD_LO_NS + CLK_NS - 1) / CLK_NS - 1);
	localparam logic [TMR_W-1:0] RD_HI_T = TMR_W'((RD_HI_NS + CLK_NS - 1) / CLK_NS - 1);
	localparam logic [TMR_W-1:0] TRB_T = TMR_W'((TRB_NS + CLK_NS - 1) / CLK_NS - 1);
	localparam logic [TMR_W-1:0] WHR_T = TMR_W'((WHR_NS + CLK_NS - 1) / CLK_NS - 1);
	localparam logic [TMR_W-1:0] CEH_T = TMR_W'((CEH_NS + CLK_NS - 1) / CLK_NS - 1);

	// device command bytes
	localparam logic [7:0] CMD_READ_MAIN = 8'h00;
	localparam logic [7:0] CMD_READ_HALF2 = 8'h01;
	localparam logic [7:0] CMD_READ_SPARE = 8'h50;
	localparam logic [7:0] CMD_DATA_IN = 8'h80;
	localparam logic [7:0] CMD_PROG_GO = 8'h10;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
	localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_ID = 8'h90;
	localparam logic [7:0] CMD_RESET = 8'hff;
	localparam logic [7:0] ID_ADDR = 8'h00;

	// operation codes written by software
	localparam logic [2:0] OP_READ_MAIN = 3'h0;
	localparam logic [2:0] OP_READ_HALF2 = 3'h1;
	localparam logic [2:0] OP_READ_SPARE = 3'h2;
	localparam logic [2:0] OP_PROG = 3'h3;
	localparam logic [2:0] OP_ERASE = 3'h4;
	localparam logic [2:0] OP_STATUS = 3'h5;
	localparam logic [2:0] OP_ID = 3'h6;
	localparam logic [2:0] OP_RESET = 3'h7;

	// own register map
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_COUNT = 8'h08;
	localparam logic [7:0] REG_CTRL = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_WDATA = 8'h14;
	localparam logic [7:0] REG_RDATA = 8'h18;
	localparam int CTRL_PROT_BIT = 0;
	localparam int CTRL_SPARE_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam int ST_DONE_BIT = 1;
	localparam int ST_REFUSED_BIT = 2;

	// device status byte and page layout
	localparam logic [7:0] RESULT_RESET = 8'hc0;
	localparam int SR_FAIL_BIT = 0;
	localparam logic [9:0] COL_HALF2 = 10'h100;
	localparam logic [9:0] COL_SPARE = 10'h200;
	localparam logic [9:0] COL_LAST = 10'h20f;
	localparam logic [1:0] ADDR_LAST = 2'h2;
	localparam logic [1:0] ERASE_FIRST = 2'h1;
	localparam int ID_READS = 2;
	localparam logic [1:0] PROG_MAIN_MAX = 2'h2;
	localparam logic [1:0] PROG_SPARE_MAX = 2'h3;
endpackage

//--- core/nfc_sync.sv
// two-flop synchroniser for the pins coming back from the card
// assumes a synchronous-release active-low reset from the top
`timescale 1ns/1ps
`default_nettype none
module nfc_sync #(
	parameter int W = 9
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	// meta_q feeds nothing but q
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule
`default_nettype wire
